// *** logic/irq_flags_pkg.sv ***
package irq_flags_pkg;

    // Bit positions within the low interrupt control byte
    localparam int unsigned BIT_INDEX_FLAG = 7;
    localparam int unsigned BIT_OVER_FLAG = 6;
    localparam int unsigned BIT_UNDER_FLAG = 5;
    localparam int unsigned BIT_OUZ_EN = 4;
    localparam int unsigned BIT_SHARED_FLAG = 3;
    localparam int unsigned BIT_SHARED_EN = 2;
    localparam int unsigned BIT_POS_FLAG = 1;
    localparam int unsigned BIT_POS_EN = 0;

    // Reset value and flag mask of the byte
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAG_MASK = 8'hea;

    // Mode codes
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] REV_MODE_TWO = 2'h2;

    // Inputs from the counting engine and its configuration
    typedef struct packed {
        logic [15:0] position_count_value;
        logic [15:0] revolution_count_value;
        logic [15:0] position_compare_value;
        logic [15:0] shared_compare_value;
        logic [15:0] max_position_value;
        logic [1:0] position_mode;
        logic [1:0] revolution_mode_field;
        logic compare_source_select;
        logic position_stop_bit;
        logic index_gate_select;
        logic count_up;
        logic count_down;
        logic index_clear;
        logic wr_position_count;
        logic wr_position_compare;
        logic wr_shared_compare;
    } counter_view_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic rmw;
        logic [7:0] wdata;
    } reg_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] rdata;
        logic [1:0] pmode_prev;
        logic [1:0] rmode_prev;
        logic sel_prev;
        logic wr_pc_d;
        logic wr_pcc_d;
        logic wr_sc_d;
    } flags_state_t;

endpackage

// *** logic/quad_counter_irq_flags.sv ***
// The strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module quad_counter_irq_flags
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire irq_flags_pkg::counter_view_t cnt,
    input wire irq_flags_pkg::reg_req_t req,
    output logic [7:0] rdata,
    output logic irq_req
);
    import irq_flags_pkg::*;

    flags_state_t st_r;
    flags_state_t st_nxt;
    logic pos_shared_eq;
    logic rev_shared_eq;
    logic pos_cmp_eq;
    logic pos_counting;
    logic rev_on;
    logic set_index;
    logic set_over;
    logic set_under;
    logic set_shared;
    logic set_pos;
    logic [7:0] set_vec;

    // Mode test used for both mode fields
    function automatic logic mode_on(input logic [1:0] m);
        mode_on = (m != MODE_DISABLED);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Comparators
    assign pos_shared_eq = (cnt.position_count_value == cnt.shared_compare_value);
    assign rev_shared_eq = (cnt.revolution_count_value == cnt.shared_compare_value);
    assign pos_cmp_eq = (cnt.position_count_value == cnt.position_compare_value);
    assign pos_counting = mode_on(cnt.position_mode);
    assign rev_on = mode_on(cnt.revolution_mode_field);

    ////////////////////////////////////////////////////////////////////////
    // Flag set events
    // index clear event
    // gate and mode two block it
    assign set_index = cnt.index_clear && !cnt.index_gate_select
        && (cnt.revolution_mode_field != REV_MODE_TWO);
    assign set_over = cnt.count_up && (cnt.position_count_value == cnt.max_position_value);
    assign set_under = cnt.count_down && (cnt.position_count_value == 16'h0000);

    // Write strobes are delayed one cycle so equality is judged on the new value
    always_comb
    begin
        set_shared = 1'b0;
        if (!cnt.compare_source_select)
        begin
            set_shared = pos_counting && pos_shared_eq;
            if (!mode_on(st_r.pmode_prev) && pos_counting && pos_shared_eq)
                set_shared = 1'b1;
            if (pos_counting && (st_r.wr_pc_d || st_r.wr_sc_d) && pos_shared_eq)
                set_shared = 1'b1;
            if (st_r.sel_prev && rev_on && pos_shared_eq)
                set_shared = 1'b1;
        end
        else
        begin
            set_shared = rev_on && rev_shared_eq;
            if (rev_on && st_r.wr_sc_d && rev_shared_eq)
                set_shared = 1'b1;
            if (!mode_on(st_r.rmode_prev) && rev_on && rev_shared_eq)
                set_shared = 1'b1;
            if (!st_r.sel_prev && rev_on && rev_shared_eq)
                set_shared = 1'b1;
        end
    end

    always_comb
    begin
        set_pos = pos_counting && pos_cmp_eq;
        // leaving mode 0, or count write while stopped
        if (pos_counting && pos_cmp_eq && (!mode_on(st_r.pmode_prev)
            || (st_r.wr_pc_d && cnt.position_stop_bit)))
            set_pos = 1'b1;
        if (pos_counting && st_r.wr_pcc_d && pos_cmp_eq)
            set_pos = 1'b1;
    end

    always_comb
    begin
        set_vec = 8'h00;
        set_vec[BIT_INDEX_FLAG] = set_index;
        set_vec[BIT_OVER_FLAG] = set_over;
        set_vec[BIT_UNDER_FLAG] = set_under;
        set_vec[BIT_SHARED_FLAG] = set_shared;
        set_vec[BIT_POS_FLAG] = set_pos;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state; set wins over a clearing write in the same cycle
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pmode_prev = cnt.position_mode;
        st_nxt.rmode_prev = cnt.revolution_mode_field;
        st_nxt.sel_prev = cnt.compare_source_select;
        st_nxt.wr_pc_d = cnt.wr_position_count;
        st_nxt.wr_pcc_d = cnt.wr_position_compare;
        st_nxt.wr_sc_d = cnt.wr_shared_compare;
        if (req.wr)
        begin
            // flags clear on 0 only, enables store
            st_nxt.flags = (st_r.flags & FLAG_MASK & req.wdata)
                | (req.wdata & ~FLAG_MASK);
        end
        st_nxt.flags = st_nxt.flags | set_vec;
        if (req.rd)
        begin
            st_nxt.rdata = req.rmw ? (st_r.flags | FLAG_MASK) : st_r.flags;
        end
    end

    // Clock enable freezes everything
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= '0;
        else if (clk_en)
            st_r <= st_nxt;
    end

    assign rdata = st_r.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request
    // enabled groups
    assign irq_req = (st_r.flags[BIT_OUZ_EN] && (st_r.flags[BIT_INDEX_FLAG]
            || st_r.flags[BIT_OVER_FLAG] || st_r.flags[BIT_UNDER_FLAG]))
        || (st_r.flags[BIT_SHARED_EN] && st_r.flags[BIT_SHARED_FLAG])
        || (st_r.flags[BIT_POS_EN] && st_r.flags[BIT_POS_FLAG]);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_over_event;
        clk_en && set_over;
    endsequence

    chk_index_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && set_index |=> st_r.flags[BIT_INDEX_FLAG])
        else $error("index flag not set");
    chk_index_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        cnt.index_gate_select |-> !set_index)
        else $error("index flag set in gate mode");
    chk_flag_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.wr && req.wdata[BIT_POS_FLAG] && st_r.flags[BIT_POS_FLAG]
        |=> st_r.flags[BIT_POS_FLAG])
        else $error("write of 1 cleared flag");
    chk_rmw_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.rd && req.rmw |=> (rdata & FLAG_MASK) == FLAG_MASK)
        else $error("rmw read not 1");
    chk_over_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_over_event |=> st_r.flags[BIT_OVER_FLAG])
        else $error("overflow flag missing");
    chk_under_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && cnt.count_down && cnt.position_count_value == 16'h0000
        |=> st_r.flags[BIT_UNDER_FLAG])
        else $error("underflow flag missing");
    chk_ouz_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r.flags[BIT_OUZ_EN] && st_r.flags[BIT_OVER_FLAG] |-> irq_req)
        else $error("over irq missing");
    chk_shared_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        !irq_req |-> !(st_r.flags[BIT_SHARED_EN] && st_r.flags[BIT_SHARED_FLAG]))
        else $error("shared irq missing");
    chk_pos_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && pos_counting && pos_cmp_eq |=> st_r.flags[BIT_POS_FLAG])
        else $error("position compare flag missing");

    ////////////////////////////////////////////////////////////////////////
    // Building blocks: which compare source is live this cycle
    sequence s_sel_pos;
        clk_en && !cnt.compare_source_select;
    endsequence

    sequence s_sel_rev;
        clk_en && cnt.compare_source_select;
    endsequence

    // A clearing write that no set event races
    sequence s_clear_over;
        clk_en && req.wr && !req.wdata[BIT_OVER_FLAG] && !set_over;
    endsequence

    // Flag already low, so only a set event may raise it
    sequence s_index_low;
        clk_en && !st_r.flags[BIT_INDEX_FLAG];
    endsequence

    sequence s_pos_low;
        clk_en && !st_r.flags[BIT_POS_FLAG];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Index flag blocking

    // Index flag stays down while the index pin acts as a gate
    chk_gate_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_index_low ##0 cnt.index_gate_select |=> !st_r.flags[BIT_INDEX_FLAG])
        else $error("index flag set while gating");

    // Revolution mode two clears the counter without flagging it
    chk_mode_two: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_index_low ##0 (cnt.revolution_mode_field == REV_MODE_TWO)
        |=> !st_r.flags[BIT_INDEX_FLAG])
        else $error("index flag set in revolution mode two");

    ////////////////////////////////////////////////////////////////////////
    // Software access

    // Clearing write lands when nothing sets the flag at the same edge
    chk_over_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_clear_over |=> !st_r.flags[BIT_OVER_FLAG])
        else $error("overflow flag not cleared");

    // Same for the position-compare flag
    chk_pos_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.wr && !req.wdata[BIT_POS_FLAG] && !set_pos
        |=> !st_r.flags[BIT_POS_FLAG])
        else $error("position compare flag not cleared");

    chk_shared_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.wr && req.wdata[BIT_SHARED_FLAG] && st_r.flags[BIT_SHARED_FLAG]
        |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("write of 1 cleared shared flag");

    // A set index flag survives anything but a clearing write
    chk_index_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && st_r.flags[BIT_INDEX_FLAG] && !(req.wr && !req.wdata[BIT_INDEX_FLAG])
        |=> st_r.flags[BIT_INDEX_FLAG])
        else $error("index flag lost");

    // Enable bits are plain storage
    chk_en_store: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.wr |=> st_r.flags[BIT_OUZ_EN] == $past(req.wdata[BIT_OUZ_EN]))
        else $error("enable bit not stored");

    // A plain read returns the byte as it stood
    chk_plain_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.rd && !req.rmw |=> rdata == $past(st_r.flags))
        else $error("plain read data wrong");

    // The read phase forces only the flag bits; enables read true
    chk_rmw_enables: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && req.rd && req.rmw
        |=> (rdata & ~FLAG_MASK) == ($past(st_r.flags) & ~FLAG_MASK))
        else $error("rmw read altered enables");

    // Read data hold until the next read
    chk_rdata_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !req.rd |=> $stable(rdata))
        else $error("read data changed without a read");

    ////////////////////////////////////////////////////////////////////////
    // Interrupt groups and compare flags

    chk_under_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r.flags[BIT_OUZ_EN] && st_r.flags[BIT_UNDER_FLAG] |-> irq_req)
        else $error("underflow irq missing");

    chk_index_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r.flags[BIT_OUZ_EN] && st_r.flags[BIT_INDEX_FLAG] |-> irq_req)
        else $error("index irq missing");

    // Shared flag from position or revolution match
    chk_shared_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_pos ##0 (pos_counting && pos_shared_eq) |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing on position match");

    chk_shared_rev: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_rev ##0 (rev_on && rev_shared_eq) |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing on revolution match");

    // Immediate sets on mode change, compare write and select change
    chk_pmode_leave: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_pos ##0 (!mode_on(st_r.pmode_prev) && pos_counting && pos_shared_eq)
        |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing on mode leave");

    chk_shared_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_pos ##0 (pos_counting && (st_r.wr_pc_d || st_r.wr_sc_d) && pos_shared_eq)
        |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing after write");

    chk_rev_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_rev ##0 (rev_on && st_r.wr_sc_d && rev_shared_eq) |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing after compare write");

    chk_rmode_leave: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_rev ##0 (!mode_on(st_r.rmode_prev) && rev_on && rev_shared_eq)
        |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing on revolution mode leave");

    // Either direction of the select change, judged on the newly chosen source
    chk_sel_change: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rev_on && (cnt.compare_source_select != st_r.sel_prev)
        && (cnt.compare_source_select ? rev_shared_eq : pos_shared_eq)
        |=> st_r.flags[BIT_SHARED_FLAG])
        else $error("shared flag missing on select change");

    chk_shared_on: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r.flags[BIT_SHARED_EN] && st_r.flags[BIT_SHARED_FLAG] |-> irq_req)
        else $error("shared irq not raised");

    // Position-compare flag on mode leave and on writes
    chk_pmode_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !mode_on(st_r.pmode_prev) && pos_counting && pos_cmp_eq
        |=> st_r.flags[BIT_POS_FLAG])
        else $error("position flag missing on mode leave");

    chk_stop_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && pos_counting && st_r.wr_pc_d && cnt.position_stop_bit && pos_cmp_eq
        |=> st_r.flags[BIT_POS_FLAG])
        else $error("position flag missing after stopped count write");

    chk_cmp_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && pos_counting && st_r.wr_pcc_d && pos_cmp_eq |=> st_r.flags[BIT_POS_FLAG])
        else $error("position flag missing after compare write");

    chk_pos_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r.flags[BIT_POS_EN] && st_r.flags[BIT_POS_FLAG] |-> irq_req)
        else $error("position irq missing");

    // A disabled position mode never raises the position-compare flag
    chk_disabled_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_pos_low ##0 !pos_counting |=> !st_r.flags[BIT_POS_FLAG])
        else $error("position flag set while disabled");

    // No request without an enabled group behind it
    chk_irq_source: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq_req |-> (st_r.flags[BIT_OUZ_EN] && (st_r.flags[BIT_INDEX_FLAG]
            || st_r.flags[BIT_OVER_FLAG] || st_r.flags[BIT_UNDER_FLAG]))
            || (st_r.flags[BIT_SHARED_EN] && st_r.flags[BIT_SHARED_FLAG])
            || (st_r.flags[BIT_POS_EN] && st_r.flags[BIT_POS_FLAG]))
        else $error("irq without enabled flag");

endmodule

`default_nettype wire

// *** testbench/engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module engine_model
(
    input wire logic core_clk,
    output var irq_flags_pkg::counter_view_t cnt
);
    import irq_flags_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Counting mode, position at maximum, values kept off both compares
    initial
    begin
        cnt = '0;
        cnt.position_mode = 2'h1;
        cnt.revolution_mode_field = 2'h1;
        cnt.max_position_value = 16'h00ff;
        cnt.position_count_value = 16'h00ff;
        cnt.position_compare_value = 16'h1234;
        cnt.shared_compare_value = 16'h5678;
        cnt.revolution_count_value = 16'h0003;
    end

    // One-cycle events {shared write, index, down, up}; idle edge after so pulses never merge
    task automatic strobe(input logic [3:0] ev);
        cnt.count_up <= ev[0];
        cnt.count_down <= ev[1];
        cnt.index_clear <= ev[2];
        cnt.wr_shared_compare <= ev[3];
        @(posedge core_clk);
        cnt.count_up <= 1'b0;
        cnt.count_down <= 1'b0;
        cnt.index_clear <= 1'b0;
        cnt.wr_shared_compare <= 1'b0;
        @(posedge core_clk);
    endtask

    // One-cycle software write pulses {compare write, count write}
    task automatic write_strobe(input logic [1:0] w);
        cnt.wr_position_count <= w[0];
        cnt.wr_position_compare <= w[1];
        @(posedge core_clk);
        cnt.wr_position_count <= 1'b0;
        cnt.wr_position_compare <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule

`default_nettype wire

// *** testbench/quad_counter_irq_flags_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module quad_counter_irq_flags_test;
    import irq_flags_pkg::*;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    reg_req_t req = '0;
    wire counter_view_t cnt;
    logic [7:0] rdata;
    logic irq_req;
    int err_total = 0;
    int check_count = 0;

    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    engine_model u_engine_model (.core_clk(core_clk), .cnt(cnt));

    quad_counter_irq_flags u_quad_counter_irq_flags (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .cnt(cnt), .req(req), .rdata(rdata), .irq_req(irq_req));

    ////////////////////////////////////////////////////////////////////////////
    // Compare, register access and closing tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobe dropped with an idle edge after it, so back-to-back calls never reassign it
    task automatic reg_wr(input logic [7:0] d);
        req.wr <= 1'b1;
        req.wdata <= d;
        @(posedge core_clk);
        req.wr <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read data stands from the cycle after the strobe until the next read
    task automatic reg_rd(input logic rmw, output logic [7:0] d);
        req.rd <= 1'b1;
        req.rmw <= rmw;
        @(posedge core_clk);
        req.rd <= 1'b0;
        req.rmw <= 1'b0;
        #1 d = rdata;
        @(posedge core_clk);
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        logic [7:0] d;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        reg_rd(1'b0, d);
        check(d, FLAGS_RESET);
        reg_wr(8'h15);
        reg_rd(1'b0, d);
        check(d, 8'h15);
        check({7'h00, irq_req}, 8'h00);
        $display("test reset_and_enables done");
        u_engine_model.strobe(4'h1);
        reg_rd(1'b0, d);
        check(d, 8'h55);
        check({7'h00, irq_req}, 8'h01);
        reg_wr(8'hff);
        reg_rd(1'b0, d);
        check(d, 8'h55);
        reg_wr(8'h15);
        u_engine_model.cnt.position_count_value <= 16'h0000;
        u_engine_model.strobe(4'h2);
        reg_rd(1'b1, d);
        check(d, 8'hff);
        reg_rd(1'b0, d);
        check(d, 8'h35);
        reg_wr(8'h15);
        u_engine_model.strobe(4'h4);
        reg_rd(1'b0, d);
        check(d, 8'h95);
        reg_wr(8'h15);
        $display("test over_under_index done");
        // Index as gate, then revolution mode two: no index flag either way
        u_engine_model.cnt.index_gate_select <= 1'b1;
        u_engine_model.strobe(4'h4);
        u_engine_model.cnt.index_gate_select <= 1'b0;
        u_engine_model.cnt.revolution_mode_field <= REV_MODE_TWO;
        u_engine_model.strobe(4'h4);
        reg_rd(1'b0, d);
        check(d, 8'h15);
        u_engine_model.cnt.revolution_mode_field <= 2'h1;
        u_engine_model.strobe(4'h2);
        reg_wr(8'he5);
        check({7'h00, irq_req}, 8'h00);
        $display("test index_blocked done");
        u_engine_model.cnt.position_count_value <= 16'h1234;
        u_engine_model.strobe(4'h0);
        reg_rd(1'b0, d);
        check(d, 8'h27);
        check({7'h00, irq_req}, 8'h01);
        u_engine_model.cnt.shared_compare_value <= 16'h1234;
        u_engine_model.strobe(4'h8);
        reg_rd(1'b0, d);
        check(d, 8'h2f);
        // Move off both matches before clearing, else the flags set again
        u_engine_model.cnt.position_count_value <= 16'h0010;
        u_engine_model.strobe(4'h0);
        reg_wr(8'h00);
        u_engine_model.cnt.compare_source_select <= 1'b1;
        u_engine_model.cnt.shared_compare_value <= 16'h0003;
        u_engine_model.strobe(4'h8);
        reg_rd(1'b0, d);
        check(d, 8'h08);
        check({7'h00, irq_req}, 8'h00);
        $display("test compare_flags done");
        // A match seen only while the clock enable is low leaves no flag
        u_engine_model.cnt.compare_source_select <= 1'b0;
        u_engine_model.strobe(4'h0);
        reg_wr(8'h00);
        clk_en <= 1'b0;
        u_engine_model.cnt.position_count_value <= 16'h1234;
        u_engine_model.strobe(4'h0);
        clk_en <= 1'b1;
        u_engine_model.cnt.position_count_value <= 16'h0010;
        u_engine_model.strobe(4'h0);
        reg_rd(1'b0, d);
        check(d, 8'h00);
        // Mode 0 ignores a match; leaving it with the match standing sets the flag
        u_engine_model.cnt.position_mode <= MODE_DISABLED;
        u_engine_model.cnt.position_count_value <= 16'h1234;
        u_engine_model.strobe(4'h0);
        reg_rd(1'b0, d);
        check(d, 8'h00);
        u_engine_model.cnt.position_mode <= 2'h1;
        u_engine_model.strobe(4'h0);
        reg_rd(1'b0, d);
        check(d, 8'h02);
        u_engine_model.cnt.position_count_value <= 16'h0020;
        reg_wr(8'h00);
        u_engine_model.cnt.position_compare_value <= 16'h0020;
        u_engine_model.write_strobe(2'b10);
        reg_rd(1'b0, d);
        check(d, 8'h02);
        u_engine_model.cnt.position_stop_bit <= 1'b1;
        u_engine_model.cnt.position_count_value <= 16'h0030;
        reg_wr(8'h00);
        u_engine_model.cnt.position_count_value <= 16'h0020;
        u_engine_model.write_strobe(2'b01);
        reg_rd(1'b0, d);
        check(d, 8'h02);
        u_engine_model.cnt.shared_compare_value <= 16'h0020;
        u_engine_model.strobe(4'h8);
        reg_rd(1'b0, d);
        check(d, 8'h0a);
        $display("test mode_and_write_sets done");
        end_of_test();
    end

    // Watchdog well beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end
endmodule

`default_nettype wire
